//--- core/crwl_pkg.sv
package crwl_pkg;
  // Register indices on the configuration bus (word index)
  localparam int KEY_FIRST_IDX = 0;
  localparam int KEY_SECOND_IDX = 1;
  localparam int STATUS_IDX = 2;
  localparam int REV_IDX = 3;
  localparam int FIRST_CFG_IDX = 4;
  // Fixed unlock keys
  localparam logic [31:0] UNLOCK_KEY_FIRST_VAL = 32'h5a3c_0f01;
  localparam logic [31:0] UNLOCK_KEY_SECOND_VAL = 32'ha5c3_f0e2;
  // Read-only revision word, arbitrary value
  localparam logic [31:0] REV_VAL = 32'h0000_0100;
  // Values after reset
  localparam logic [31:0] CFG_RST_VAL = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST_VAL = 32'h0000_0000;
  // Lock states, one-hot
  typedef enum logic [1:0] {
    CRWL_LOCKED = 2'b01,
    CRWL_OPEN = 2'b10
  } crwl_lock_state_t;
endpackage

//--- core/crwl_key_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crwl_key_if;
  logic key_wr;
  logic key_sel;
  logic [31:0] key_data;
  logic locked;
  modport lock (input key_wr, input key_sel, input key_data, output locked);
  modport bank (output key_wr, output key_sel, output key_data, input locked);
endinterface
`default_nettype wire

//--- core/crwl_lock.sv
`timescale 1ns/1ps
`default_nettype none
module crwl_lock (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Key writes and lock state
  crwl_key_if.lock kif
);
  typedef struct packed {
    crwl_pkg::crwl_lock_state_t st;
    logic first_ok;
    logic second_ok;
  } crwl_lock_t;

  crwl_lock_t s_q, s_d;
  logic key_match;

  always_comb begin
    s_d = s_q;
    key_match = kif.key_sel ? (kif.key_data == crwl_pkg::UNLOCK_KEY_SECOND_VAL)
                            : (kif.key_data == crwl_pkg::UNLOCK_KEY_FIRST_VAL);
    if (kif.key_wr) begin
      if (!key_match) begin
        s_d.st = crwl_pkg::CRWL_LOCKED;
        s_d.first_ok = 1'b0;
        s_d.second_ok = 1'b0;
      end else begin
        if (kif.key_sel) begin
          s_d.second_ok = 1'b1;
        end else begin
          s_d.first_ok = 1'b1;
        end
        // Either order is accepted; one key alone never opens
        if (s_d.first_ok && s_d.second_ok) begin
          s_d.st = crwl_pkg::CRWL_OPEN;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{st: crwl_pkg::CRWL_LOCKED, first_ok: 1'b0, second_ok: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign kif.locked = (s_q.st == crwl_pkg::CRWL_LOCKED);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_RESET_LOCKED: assert property ($rose(reset_n) |-> kif.locked)
    else $error("lock not engaged after reset");
  AST_WRONG_KEY_LOCKS: assert property (kif.key_wr && !key_match |=> kif.locked [*2])
    else $error("wrong key did not re-engage lock");
  AST_SINGLE_KEY_STAYS: assert property (
    kif.locked && kif.key_wr && !kif.key_sel && !s_q.second_ok |=> kif.locked)
    else $error("one key released the lock");
  AST_OPEN_NEEDS_KEY: assert property ($fell(kif.locked) |-> $past(kif.key_wr && key_match))
    else $error("lock released without a key write");
endmodule
`default_nettype wire

//--- core/crwl_top.sv
`timescale 1ns/1ps
`default_nettype none
module crwl_top #(
  parameter int ADDR_W = 4,
  parameter int NREGS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Configuration bus, shared by all cores
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ready,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_wr_dropped,
  // Lock state
  output logic cfg_locked
);
  typedef struct packed {
    logic [NREGS-1:0][31:0] bank;
    logic [31:0] rdata;
    logic rvalid;
    logic dropped;
  } crwl_bank_t;

  crwl_bank_t s_q, s_d;
  crwl_key_if kif ();

  function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
    return (int'(a) >= crwl_pkg::FIRST_CFG_IDX) && (int'(a) < NREGS);
  endfunction

  // Single lock instance: every core sees the same state
  crwl_lock u_lock (
    .clk(clk),
    .reset_n(reset_n),
    .kif(kif)
  );

  logic wr;
  logic rd;
  assign wr = cfg_req && cfg_we;
  assign rd = cfg_req && !cfg_we;

  // Key registers stay writable while locked, else the lock could never open
  assign kif.key_wr = wr && (int'(cfg_addr) == crwl_pkg::KEY_FIRST_IDX ||
                             int'(cfg_addr) == crwl_pkg::KEY_SECOND_IDX);
  assign kif.key_sel = (int'(cfg_addr) == crwl_pkg::KEY_SECOND_IDX);
  assign kif.key_data = cfg_wdata;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = rd;
    s_d.dropped = 1'b0;
    if (wr && is_cfg(cfg_addr)) begin
      if (kif.locked) begin
        s_d.dropped = 1'b1;
      end else begin
        s_d.bank[cfg_addr] = cfg_wdata;
      end
    end
    if (rd) begin
      // Keys read as zero so software cannot learn them back
      if (int'(cfg_addr) == crwl_pkg::STATUS_IDX) begin
        s_d.rdata = {31'h0000_0000, kif.locked};
      end else if (int'(cfg_addr) == crwl_pkg::REV_IDX) begin
        s_d.rdata = crwl_pkg::REV_VAL;
      end else if (is_cfg(cfg_addr)) begin
        s_d.rdata = s_q.bank[cfg_addr];
      end else begin
        s_d.rdata = crwl_pkg::RDATA_RST_VAL;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.bank <= {NREGS{crwl_pkg::CFG_RST_VAL}};
      s_q.rdata <= crwl_pkg::RDATA_RST_VAL;
      s_q.rvalid <= 1'b0;
      s_q.dropped <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg_ready = 1'b1;
  assign cfg_rdata = s_q.rdata;
  assign cfg_rvalid = s_q.rvalid;
  assign cfg_wr_dropped = s_q.dropped;
  assign cfg_locked = kif.locked;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_LOCKED_NO_WRITE: assert property (
    wr && kif.locked && is_cfg(cfg_addr) |=> s_q.bank == $past(s_q.bank) && cfg_wr_dropped)
    else $error("write changed the bank while locked");
  AST_READ_ANSWERS: assert property (
    rd && is_cfg(cfg_addr) |=> cfg_rvalid && cfg_rdata == $past(s_q.bank[cfg_addr]))
    else $error("read did not return register contents");
  AST_OPEN_WRITES: assert property (
    wr && !kif.locked && is_cfg(cfg_addr) |=> s_q.bank[$past(cfg_addr)] == $past(cfg_wdata))
    else $error("write lost while open");
  AST_RO_READ: assert property (
    rd && int'(cfg_addr) == crwl_pkg::REV_IDX |=> cfg_rdata == crwl_pkg::REV_VAL)
    else $error("read-only word changed");
endmodule
`default_nettype wire

//--- tb/crwl_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module crwl_core_model (
  // Bus side of one core
  input wire logic clk,
  output logic req,
  output logic we,
  output logic [3:0] addr,
  output logic [31:0] wdata
);
  initial {req, we, addr, wdata} = '0;
  // Ready is constant, so a request stands for exactly its taking edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
  endtask
  // Released lines show the inverse so stale values never look valid
  task automatic idle();
    @(posedge clk);
    req <= 1'b0;
    we <= ~we;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_config_register_write_lock.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, b, a); end end
module tb_config_register_write_lock;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req, we, ready, rvalid, dropped, locked;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, m_rd;
  logic [31:0] bank [16];
  logic [31:0] key [2] = '{crwl_pkg::UNLOCK_KEY_FIRST_VAL, crwl_pkg::UNLOCK_KEY_SECOND_VAL};
  // One key pair for every core
  logic m_lk, m_k0, m_k1, m_rv, m_dr;
  int err_total = 0;
  int n_compared = 0;
  int k;
  initial forever #2.5 clk = ~clk;
  crwl_core_model crwl_core_model_inst (.clk(clk), .req(req), .we(we), .addr(addr),
    .wdata(wdata));
  crwl_top crwl_top_inst (.clk(clk), .reset_n(reset_n), .cfg_req(req), .cfg_we(we),
    .cfg_addr(addr), .cfg_wdata(wdata), .cfg_ready(ready), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .cfg_wr_dropped(dropped), .cfg_locked(locked));
  // Negedge: outputs show the last taken request, inputs show the next one
  always @(negedge clk) begin
    if (!reset_n) begin
      {m_lk, m_k0, m_k1, m_rv, m_dr, m_rd} = {5'h10, 32'h0};
      foreach (bank[i]) bank[i] = 32'h0;
    end else begin
      `CHK("locked", locked, m_lk)
      `CHK("dropped", dropped, m_dr)
      `CHK("rvalid", rvalid, m_rv)
      `CHK("rdata", rdata, m_rd)
      `CHK("ready", ready, 1'b1)
      m_rv = req && !we;
      m_dr = req && we && addr >= 4 && m_lk;
      if (m_rv) m_rd = addr == 2 ? {31'h0, m_lk} : addr == 3 ? crwl_pkg::REV_VAL :
        addr >= 4 ? bank[addr] : 32'h0;
      if (req && we && addr >= 4 && !m_lk) bank[addr] = wdata;
      if (req && we && addr < 2) begin
        if (wdata !== key[addr[0]]) {m_k0, m_k1} = 2'h0;
        else if (addr[0]) m_k1 = 1'b1;
        else m_k0 = 1'b1;
        m_lk = !(m_k0 && m_k1);
      end
    end
  end
  task automatic go(input logic w, input logic [3:0] a, input logic [31:0] d);
    crwl_core_model_inst.acc(w, a, d);
  endtask
  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h07333927));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    go(1'b1, 4'h2, 32'h0);
    go(1'b0, 4'h2, 32'h0);
    go(1'b1, 4'h4, 32'h0000_00a5);
    go(1'b0, 4'h4, 32'h0);
    go(1'b1, 4'h0, key[0]);
    go(1'b1, 4'h5, 32'h1);
    go(1'b1, 4'h1, ~key[1]);
    go(1'b1, 4'h1, key[1]);
    go(1'b1, 4'h0, key[0]);
    for (int i = 2; i < 16; i++) go(1'b1, 4'(i), $urandom);
    for (int i = 0; i < 16; i++) go(1'b0, 4'(i), 32'h0);
    go(1'b1, 4'h0, 32'h0);
    go(1'b1, 4'h6, 32'h1);
    crwl_core_model_inst.idle();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    // Keys are biased in so the lock toggles often under random traffic
    repeat (600) begin
      k = $urandom % 8;
      if (k < 2) go(1'b1, 4'(k), key[k]);
      else go(1'($urandom), 4'($urandom), $urandom);
    end
    crwl_core_model_inst.idle();
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
